// ==== core/ppecb_edge_bank.sv ====
// edge compare register bank and period timer of the pulse sequencer
// What this block does
// [RL1] start LED1 sampling at its start count
// [RL2] end LED1 sampling at count in 08h
// [RL3] LED1 drive on at count in 09h
// [RL4] LED1 drive off at count in 0Ah
// [RL5] start ambient LED1 sampling at 0Bh count
// [RL6] end ambient LED1 sampling at 0Ch count
// [RL7] LED2 conversion on at 0Dh count
// [RL8] LED2 conversion off at 0Eh count
// [RL9] ambient LED2 conversion on at 0Fh
// [RL10] ambient LED2 conversion off at 10h
// [RL11] counts are 4 MHz cycles from period start
// [RL12] host writes zero to bits 23:16
// [RL13] edge registers reset to zero
// [RL14] timer held while hold bit is one
// [RL15] readback only with read enable set
// [RL16] LED1 sample counts are 16 bits wide
`timescale 1ns/1ps
`include "ppecb_consts.svh"

module ppecb_edge_bank (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire ppecb_pkg::ppecb_reg_req_s req,
  output logic [23:0] rdata,
  output logic rvalid,
  output ppecb_pkg::ppecb_phase_s phases,
  output logic [15:0] timer_count,
  output logic timer_running
);

  localparam int NREG = 10;

  // =====================================
  // register storage
  logic [15:0] edge_q [NREG];
  logic [15:0] period_q;
  logic read_en_q;
  logic timer_hold_q;
  logic [15:0] count_q;
  logic tick;
  ppecb_pkg::ppecb_timer_e state_q;
  logic [3:0] widx;
  logic widx_hit;

  // =====================================
  // offset decode to edge index
  always_comb begin
    widx = 4'h0;
    widx_hit = 1'b1;
    case (req.addr)
      `PPECB_OFF_LED1_SAMPLE_START: widx = 4'h0;
      `PPECB_OFF_LED1_SAMPLE_END: widx = 4'h1;
      `PPECB_OFF_LED1_ON_START: widx = 4'h2;
      `PPECB_OFF_LED1_ON_END: widx = 4'h3;
      `PPECB_OFF_AMBIENT1_SAMPLE_START: widx = 4'h4;
      `PPECB_OFF_AMBIENT1_SAMPLE_END: widx = 4'h5;
      `PPECB_OFF_LED2_CONVERT_START: widx = 4'h6;
      `PPECB_OFF_LED2_CONVERT_END: widx = 4'h7;
      `PPECB_OFF_AMBIENT2_CONVERT_START: widx = 4'h8;
      `PPECB_OFF_AMBIENT2_CONVERT_END: widx = 4'h9;
      default: widx_hit = 1'b0;
    endcase
  end

  // =====================================
  // edge registers, low 16 bits kept
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NREG; i++) begin
        edge_q[i] <= `PPECB_EDGE_RESET; // see [RL13]
      end
    end else if (req.wr_en && widx_hit) begin
      edge_q[widx] <= req.wdata[15:0]; // see [RL12] see [RL16]
    end
  end

  // =====================================
  // control and period registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      read_en_q <= 1'b0;
      timer_hold_q <= 1'b0;
      period_q <= `PPECB_PERIOD_RESET;
    end else if (req.wr_en) begin
      if (req.addr == `PPECB_OFF_CONTROL) begin
        read_en_q <= req.wdata[`PPECB_CTRL_READ_BIT];
        timer_hold_q <= req.wdata[`PPECB_CTRL_TIMER_HOLD_BIT]; // see [RL14]
      end else if (req.addr == `PPECB_OFF_PERIOD_COUNT) begin
        period_q <= req.wdata[15:0];
      end
    end
  end

  // =====================================
  // readback, gated by read enable
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata <= 24'h000000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd_en && read_en_q; // see [RL15]
      if (req.rd_en && read_en_q) begin
        if (widx_hit) begin
          rdata <= {8'h00, edge_q[widx]};
        end else if (req.addr == `PPECB_OFF_PERIOD_COUNT) begin
          rdata <= {8'h00, period_q};
        end else begin
          rdata <= 24'h000000;
        end
      end
    end
  end

  // =====================================
  // period timer
  ppecb_tick_gen u_tick (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .hold(timer_hold_q),
    .tick(tick)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= ppecb_pkg::PPECB_HELD;
    end else begin
      case (state_q)
        ppecb_pkg::PPECB_HELD: if (!timer_hold_q) state_q <= ppecb_pkg::PPECB_RUN;
        ppecb_pkg::PPECB_RUN: if (timer_hold_q) state_q <= ppecb_pkg::PPECB_HELD;
        default: state_q <= ppecb_pkg::PPECB_HELD;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || timer_hold_q) begin
      count_q <= 16'h0000; // see [RL14]
    end else if (tick) begin
      if (count_q >= period_q) begin
        count_q <= 16'h0000; // see [RL11]
      end else begin
        count_q <= count_q + 16'h0001; // see [RL11]
      end
    end
  end

  assign timer_count = count_q;
  assign timer_running = (state_q == ppecb_pkg::PPECB_RUN);

  // =====================================
  // phase generators
  logic [4:0] ph;

  genvar g;
  generate
    for (g = 0; g < `PPECB_PHASES; g++) begin : gen_ph
      ppecb_phase_gen u_ph (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .hold(timer_hold_q),
        .tick(tick),
        .count(count_q),
        .start_cnt(edge_q[2 * g]), // see [RL1] see [RL3] see [RL5] see [RL7] see [RL9]
        .end_cnt(edge_q[2 * g + 1]), // see [RL2] see [RL4] see [RL6] see [RL8] see [RL10]
        .phase(ph[g])
      );
    end
  endgenerate

  assign phases.led1_sample = ph[0];
  assign phases.led1_on = ph[1];
  assign phases.ambient1_sample = ph[2];
  assign phases.led2_convert = ph[3];
  assign phases.ambient2_convert = ph[4];

endmodule : ppecb_edge_bank

// ==== shared/ppecb_consts.svh ====
// register offsets, field layout, reset values and timing counts of the edge bank
`ifndef PPECB_CONSTS_SVH
`define PPECB_CONSTS_SVH

`define PPECB_ADDR_W 8
`define PPECB_REG_W 24
`define PPECB_CNT_W 16

`define PPECB_OFF_CONTROL 8'h00
`define PPECB_OFF_LED1_SAMPLE_START 8'h07
`define PPECB_OFF_LED1_SAMPLE_END 8'h08
`define PPECB_OFF_LED1_ON_START 8'h09
`define PPECB_OFF_LED1_ON_END 8'h0A
`define PPECB_OFF_AMBIENT1_SAMPLE_START 8'h0B
`define PPECB_OFF_AMBIENT1_SAMPLE_END 8'h0C
`define PPECB_OFF_LED2_CONVERT_START 8'h0D
`define PPECB_OFF_LED2_CONVERT_END 8'h0E
`define PPECB_OFF_AMBIENT2_CONVERT_START 8'h0F
`define PPECB_OFF_AMBIENT2_CONVERT_END 8'h10
`define PPECB_OFF_PERIOD_COUNT 8'h1D

`define PPECB_CTRL_READ_BIT 0
`define PPECB_CTRL_TIMER_HOLD_BIT 1

`define PPECB_EDGE_RESET 16'h0000
`define PPECB_PERIOD_RESET 16'h0000

`define PPECB_TICK_HZ 4000000
`define PPECB_CLK_HZ 10000000
`define PPECB_PHASES 5

`endif

// ==== shared/ppecb_pkg.sv ====
// types shared by the edge bank files
package ppecb_pkg;

  typedef struct packed {
    logic led1_sample;
    logic led1_on;
    logic ambient1_sample;
    logic led2_convert;
    logic ambient2_convert;
  } ppecb_phase_s;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [23:0] wdata;
  } ppecb_reg_req_s;

  typedef enum logic [0:0] {
    PPECB_HELD,
    PPECB_RUN
  } ppecb_timer_e;

endpackage : ppecb_pkg

// ==== core/ppecb_tick_gen.sv ====
// fractional divider making the 4 MHz tick enable from the 10 MHz clock
`timescale 1ns/1ps
`include "ppecb_consts.svh"

module ppecb_tick_gen (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hold,
  output logic tick
);

  localparam logic [23:0] STEP = 24'(`PPECB_TICK_HZ);
  localparam logic [23:0] LIMIT = 24'(`PPECB_CLK_HZ);

  logic [23:0] acc_q;
  logic [24:0] sum;

  assign sum = {1'b0, acc_q} + {1'b0, STEP};

  // =====================================
  // accumulator: 2 ticks per 5 clocks
  always_ff @(posedge ref_clk) begin
    if (sys_rst || hold) begin
      acc_q <= 24'h000000;
      tick <= 1'b0;
    end else if (sum >= {1'b0, LIMIT}) begin
      acc_q <= 24'(sum - {1'b0, LIMIT});
      tick <= 1'b1;
    end else begin
      acc_q <= sum[23:0];
      tick <= 1'b0;
    end
  end

endmodule : ppecb_tick_gen

// ==== core/ppecb_phase_gen.sv ====
// one phase output set and cleared by start and end counts
`timescale 1ns/1ps
`include "ppecb_consts.svh"

module ppecb_phase_gen (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hold,
  input wire logic tick,
  input wire logic [15:0] count,
  input wire logic [15:0] start_cnt,
  input wire logic [15:0] end_cnt,
  output logic phase
);

  // =====================================
  // set on start match, end match wins
  always_ff @(posedge ref_clk) begin
    if (sys_rst || hold) begin
      phase <= 1'b0;
    end else if (tick) begin
      if (count == end_cnt) begin
        phase <= 1'b0;
      end else if (count == start_cnt) begin
        phase <= 1'b1;
      end
    end
  end

endmodule : ppecb_phase_gen

// ==== tb/ppecb_analog_model.sv ====
// analog side model counting timer ticks inside each phase
`timescale 1ns/1ps
module ppecb_analog_model (
  input wire logic ref_clk,
  input wire logic clr,
  input wire ppecb_pkg::ppecb_phase_s phases,
  input wire logic [15:0] timer_count,
  output logic [4:0][7:0] ticks
);
  logic [15:0] last_q;
  always_ff @(posedge ref_clk) begin
    last_q <= timer_count;
    for (int i = 0; i < 5; i++) begin
      if (clr) begin
        ticks[i] <= 8'h00;
      end else if (phases[i] && timer_count != last_q) begin
        ticks[i] <= ticks[i] + 8'h01;
      end
    end
  end
endmodule : ppecb_analog_model

// ==== tb/ppecb_edge_bank_sva.sv ====
// assertions on the edge bank ports
`timescale 1ns/1ps
module ppecb_edge_bank_sva (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire ppecb_pkg::ppecb_reg_req_s req,
  input wire logic [23:0] rdata,
  input wire logic rvalid,
  input wire ppecb_pkg::ppecb_phase_s phases,
  input wire logic [15:0] timer_count,
  input wire logic timer_running
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  sequence held_s;
    !timer_running ##1 !timer_running;
  endsequence
  reset_zero_a: assert property ($past(sys_rst) |-> !rvalid && phases == '0
    && timer_count == 16'h0000) else $error("not clear");
  run_start_a: assert property ($past(sys_rst) |-> !timer_running ##1 timer_running)
    else $error("no start");
  hold_clear_a: assert property (held_s |-> timer_count == 16'h0000 && phases == '0)
    else $error("hold leak");
  read_cause_a: assert property (rvalid |-> $past(req.rd_en))
    else $error("stray rvalid");
  read_hold_a: assert property ($changed(rdata) |-> rvalid)
    else $error("rdata moved");
  count_step_a: assert property ($changed(timer_count) && timer_count != 16'h0000
    |-> timer_count == $past(timer_count) + 16'h0001) else $error("bad step");
  tick_space_a: assert property ($changed(timer_count)
    |=> $stable(timer_count) || timer_count == 16'h0000) else $error("tick burst");
  tick_bound_a: assert property (timer_running && timer_count != 16'h0000
    |-> ##[1:3] $changed(timer_count)) else $error("tick late");
endmodule : ppecb_edge_bank_sva

// ==== tb/ppecb_edge_bank_tb_top.sv ====
// top testbench of the edge bank
`timescale 1ns/1ps
module ppecb_edge_bank_tb_top;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clr = 1'b0;
  ppecb_pkg::ppecb_reg_req_s req = '0;
  logic [23:0] rdata;
  logic rvalid;
  ppecb_pkg::ppecb_phase_s phases;
  logic [15:0] timer_count;
  logic timer_running;
  logic [4:0][7:0] ticks;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  ppecb_edge_bank u_ppecb_edge_bank (.ref_clk, .sys_rst, .req, .rdata, .rvalid, .phases,
    .timer_count, .timer_running);
  ppecb_analog_model u_ppecb_analog_model (.ref_clk, .clr, .phases, .timer_count, .ticks);
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    req = '{1'b1, 1'b0, a, d};
    step();
    req.wr_en = 1'b0;
    step();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [23:0] e, input logic v);
    req = '{1'b0, 1'b1, a, 24'h000000};
    step();
    req.rd_en = 1'b0;
    chk(rvalid, v);
    if (v) chk(rdata, e);
    step();
  endtask : rd
  task automatic wrap;
    while (timer_count === 16'h0000) step();
    while (timer_count !== 16'h0000) step();
  endtask : wrap
  function automatic logic [23:0] ev(input int i);
    return (i % 2) ? 24'(4 + 7 * (i / 2)) : 24'(2 + 6 * (i / 2));
  endfunction : ev
  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    wr(8'h00, 24'h000001);
    chk(timer_running, 24'h000001);
    for (int i = 0; i < 10; i++) rd(8'h07 + 8'(i), 24'h000000, 1'b1);
    for (int i = 0; i < 10; i++) wr(8'h07 + 8'(i), ev(i));
    for (int i = 0; i < 10; i++) rd(8'h07 + 8'(i), ev(i), 1'b1);
    rd(8'h05, 24'h000000, 1'b1);
    wr(8'h1D, 24'h000028);
    wr(8'h00, 24'h000000);
    rd(8'h08, 24'h000000, 1'b0);
    wrap();
    clr = 1'b1;
    step();
    clr = 1'b0;
    wrap();
    for (int k = 0; k < 5; k++) chk(ticks[4 - k], 24'(2 + k)); // to
    wr(8'h00, 24'h000002);
    step();
    chk(timer_count, 24'h000000);
    chk(phases, 24'h000000);
    chk(timer_running, 24'h000000);
    end_of_test();
  end
endmodule : ppecb_edge_bank_tb_top
bind ppecb_edge_bank ppecb_edge_bank_sva u_ppecb_edge_bank_sva (.ref_clk, .sys_rst, .req,
  .rdata, .rvalid, .phases, .timer_count, .timer_running);
